// ---- core/spcr_pkg.sv ----
// constants for the synthesizer configuration register block
package spcr_pkg;
    localparam int ADDR_W = 10;
    localparam int DATA_W = 32;
    // printed offsets are register indices; byte address is four times
    localparam logic [7:0] IDX_OSC_ENABLE_CTRL = 8'h81;
    localparam logic [7:0] IDX_REF_SOURCE_SEL  = 8'h83;
    localparam logic [7:0] IDX_SECOND_INT_CTRL = 8'h88;
    localparam logic [7:0] IDX_SECOND_FRAC_HI  = 8'h89;
    localparam logic [7:0] IDX_SECOND_FRAC_MID = 8'h8a;
    localparam logic [7:0] IDX_SECOND_FRAC_LO  = 8'h8b;
    localparam logic [7:0] IDX_THIRD_INT_CTRL  = 8'h8c;
    localparam logic [7:0] IDX_THIRD_FRAC_HI   = 8'h8d;
    localparam logic [7:0] IDX_THIRD_FRAC_MID  = 8'h8e;
    localparam logic [7:0] IDX_THIRD_FRAC_LO   = 8'h8f;
    localparam logic [7:0] IDX_SEQUENCER_CTRL  = 8'h96;
    localparam logic [7:0] IDX_SOFT_RESET      = 8'h7f;
    // field positions
    localparam int BIT_OSC_ENABLE    = 7;
    localparam int BIT_SECOND_ENABLE = 5;
    localparam int BIT_THIRD_ENABLE  = 4;
    localparam int BIT_RSVD_ZERO     = 0;
    localparam int BIT_RSVD_FOUR     = 4;
    localparam int BIT_REF_SELECT    = 1;
    localparam int BIT_THIRD_FROM_FLL = 0;
    localparam int BIT_FRAC_MODE     = 6;
    localparam int MULT_MSB          = 4;
    localparam int BIT_SEQ_ENABLE    = 1;
    localparam int MULT_W            = 5;
    localparam int FRAC_W            = 24;
    // reset values
    localparam logic       RST_FRAC_MODE   = 1'b1;
    localparam logic [4:0] RST_INT_MULT    = 5'h07;
    localparam logic [7:0] RST_SECOND_HI   = 8'h1c;
    localparam logic [7:0] RST_SECOND_MID  = 8'h71;
    localparam logic [7:0] RST_SECOND_LO   = 8'hc7;
    localparam logic [7:0] RST_THIRD_HI    = 8'h48;
    localparam logic [7:0] RST_THIRD_MID   = 8'h22;
    localparam logic [7:0] RST_THIRD_LO    = 8'h00;
    localparam logic       RST_SEQ_ENABLE  = 1'b1;
    localparam logic       RST_ENABLE_FREE = 1'b1;
    localparam logic       RST_RSVD        = 1'b1;
    localparam logic       RST_REF_SELECT  = 1'b0;
    localparam logic       RST_FROM_FLL    = 1'b0;
    localparam logic [31:0] UNMAPPED_READ  = 32'h0000_0000;
    // bus answer states
    typedef enum logic [1:0] {
        SPCR_IDLE = 2'b00,
        SPCR_ACK  = 2'b01
    } spcr_bus_state_t;
endpackage

// ---- core/spcr_regs.sv ----
// synthesizer and oscillator configuration registers on avalon-mm
//
// Implementation choice: register access over Avalon-MM.
`timescale 1ns/100ps
`default_nettype none
module spcr_regs (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [9:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        clock_lockout_override,
    input  wire logic        boot_strap_pin,
    input  wire logic        internal_osc_clk,
    input  wire logic        master_clk_in,
    input  wire logic        freq_locked_loop_clk,
    output logic             internal_osc_enable,
    output logic             second_synth_enable,
    output logic             third_synth_enable,
    output logic             second_synth_ref_clk,
    output logic             third_synth_ref_clk,
    output logic             second_synth_frac_mode,
    output logic [4:0]       second_synth_int_mult,
    output logic [23:0]      second_synth_frac_mult,
    output logic             third_synth_frac_mode,
    output logic [4:0]       third_synth_int_mult,
    output logic [23:0]      third_synth_frac_mult,
    output logic             synth_ref_select,
    output logic             third_synth_from_fll,
    output logic             synth_sequencer_enable
);
    spcr_pkg::spcr_bus_state_t state_reg;
    spcr_pkg::spcr_bus_state_t state_next;
    logic        ovd_sync;
    logic        strap_sync;
    logic        osc_en_reg;
    logic        second_en_reg;
    logic        third_en_reg;
    logic        ref_sel_reg;
    logic        from_fll_reg;
    logic        second_frac_reg;
    logic [4:0]  second_mult_reg;
    logic [7:0]  second_hi_reg;
    logic [7:0]  second_mid_reg;
    logic [7:0]  second_lo_reg;
    logic        third_frac_reg;
    logic [4:0]  third_mult_reg;
    logic [7:0]  third_hi_reg;
    logic [7:0]  third_mid_reg;
    logic [7:0]  third_lo_reg;
    logic        seq_en_reg;
    logic [31:0] rdata_reg;
    logic        prev_locked_osc_reg;
    logic        prev_locked_synth_reg;

    // pins are asynchronous to clk
    spcr_sync #(.RESET_VAL(1'b0)) u_ovd_sync (
        .clk       (clk),
        .rst       (rst),
        .pin_in    (clock_lockout_override),
        .level_out (ovd_sync)
    );
    spcr_sync #(.RESET_VAL(1'b0)) u_strap_sync (
        .clk       (clk),
        .rst       (rst),
        .pin_in    (boot_strap_pin),
        .level_out (strap_sync)
    );

    function automatic logic idx_hit(input logic [9:0] addr,
                                     input logic [7:0] idx);
        idx_hit = (addr[9:2] == idx) && (addr[1:0] == 2'b00);
    endfunction

    wire       access     = avs_read || avs_write;
    wire       take       = access && (state_reg == spcr_pkg::SPCR_IDLE);
    // writes land on the edge that ends the wait, as the master sees it
    wire       commit     = access && (state_reg == spcr_pkg::SPCR_ACK);
    wire       wr         = commit && avs_write && avs_byteenable[0];
    wire       wr_hi      = commit && avs_write && avs_byteenable[1];
    wire [7:0] wd         = avs_writedata[7:0];
    wire       locked_osc = !ovd_sync && !strap_sync;
    wire       locked_syn = !ovd_sync;
    wire       hit_osc    = idx_hit(avs_address, spcr_pkg::IDX_OSC_ENABLE_CTRL);
    wire       hit_ref    = idx_hit(avs_address, spcr_pkg::IDX_REF_SOURCE_SEL);
    wire       hit_s2i    = idx_hit(avs_address, spcr_pkg::IDX_SECOND_INT_CTRL);
    wire       hit_s2h    = idx_hit(avs_address, spcr_pkg::IDX_SECOND_FRAC_HI);
    wire       hit_s2m    = idx_hit(avs_address, spcr_pkg::IDX_SECOND_FRAC_MID);
    wire       hit_s2l    = idx_hit(avs_address, spcr_pkg::IDX_SECOND_FRAC_LO);
    wire       hit_s3i    = idx_hit(avs_address, spcr_pkg::IDX_THIRD_INT_CTRL);
    wire       hit_s3h    = idx_hit(avs_address, spcr_pkg::IDX_THIRD_FRAC_HI);
    wire       hit_s3m    = idx_hit(avs_address, spcr_pkg::IDX_THIRD_FRAC_MID);
    wire       hit_s3l    = idx_hit(avs_address, spcr_pkg::IDX_THIRD_FRAC_LO);
    wire       hit_seq    = idx_hit(avs_address, spcr_pkg::IDX_SEQUENCER_CTRL);
    wire       hit_srst   = idx_hit(avs_address, spcr_pkg::IDX_SOFT_RESET);
    // byte lane 0 or 1 written counts as a write to the soft reset
    wire       soft_rst   = hit_srst && (wr || wr_hi);
    wire       defaults   = rst || soft_rst;
    // lock released: fall back to the unlocked default of one
    wire       osc_unlock = prev_locked_osc_reg && !locked_osc;
    wire       syn_unlock = prev_locked_synth_reg && !locked_syn;

    // effective enables, forced while locked
    wire osc_eff    = locked_osc ? 1'b0 : osc_en_reg;
    wire second_eff = locked_syn ? 1'b0 : second_en_reg;
    wire third_eff  = locked_syn ? 1'b0 : third_en_reg;

    // read data view; unused bits read zero, reserved bits read one
    wire [15:0] rd_osc = {8'h00, osc_eff, 1'b0, second_eff, third_eff,
                          3'b000, spcr_pkg::RST_RSVD};
    wire [15:0] rd_ref = {11'h000, spcr_pkg::RST_RSVD, 2'b00,
                          ref_sel_reg, from_fll_reg};
    wire [15:0] rd_s2i = {9'h000, second_frac_reg, 1'b0, second_mult_reg};
    wire [15:0] rd_s3i = {9'h000, third_frac_reg, 1'b0, third_mult_reg};
    wire [15:0] rd_seq = {14'h0000, seq_en_reg, spcr_pkg::RST_RSVD};
    wire [15:0] rd_mux =
        hit_osc ? rd_osc :
        hit_ref ? rd_ref :
        hit_s2i ? rd_s2i :
        hit_s2h ? {8'h00, second_hi_reg} :
        hit_s2m ? {8'h00, second_mid_reg} :
        hit_s2l ? {8'h00, second_lo_reg} :
        hit_s3i ? rd_s3i :
        hit_s3h ? {8'h00, third_hi_reg} :
        hit_s3m ? {8'h00, third_mid_reg} :
        hit_s3l ? {8'h00, third_lo_reg} :
        hit_seq ? rd_seq : 16'h0000;

    // one wait cycle, answer on the second cycle of the request
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            spcr_pkg::SPCR_IDLE: begin
                if (access) begin
                    state_next = spcr_pkg::SPCR_ACK;
                end
            end
            spcr_pkg::SPCR_ACK: begin
                state_next = spcr_pkg::SPCR_IDLE;
            end
            default: begin
                state_next = spcr_pkg::SPCR_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= spcr_pkg::SPCR_IDLE;
            rdata_reg <= spcr_pkg::UNMAPPED_READ;
        end else begin
            state_reg <= state_next;
            if (take) begin
                rdata_reg <= {16'h0000, rd_mux};
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            prev_locked_osc_reg   <= 1'b0;
            prev_locked_synth_reg <= 1'b0;
        end else begin
            prev_locked_osc_reg   <= locked_osc;
            prev_locked_synth_reg <= locked_syn;
        end
    end

    // enables: writes masked while locked
    always_ff @(posedge clk) begin
        if (defaults || osc_unlock) begin
            osc_en_reg <= spcr_pkg::RST_ENABLE_FREE;
        end else if (wr && hit_osc && !locked_osc) begin
            osc_en_reg <= wd[spcr_pkg::BIT_OSC_ENABLE];
        end
    end

    always_ff @(posedge clk) begin
        if (defaults || syn_unlock) begin
            second_en_reg <= spcr_pkg::RST_ENABLE_FREE;
            third_en_reg  <= spcr_pkg::RST_ENABLE_FREE;
        end else if (wr && hit_osc && !locked_syn) begin
            second_en_reg <= wd[spcr_pkg::BIT_SECOND_ENABLE];
            third_en_reg  <= wd[spcr_pkg::BIT_THIRD_ENABLE];
        end
    end

    always_ff @(posedge clk) begin
        if (defaults) begin
            ref_sel_reg  <= spcr_pkg::RST_REF_SELECT;
            from_fll_reg <= spcr_pkg::RST_FROM_FLL;
            seq_en_reg   <= spcr_pkg::RST_SEQ_ENABLE;
        end else begin
            if (wr && hit_ref) begin
                ref_sel_reg  <= wd[spcr_pkg::BIT_REF_SELECT];
                from_fll_reg <= wd[spcr_pkg::BIT_THIRD_FROM_FLL];
            end
            // not forced low by mclk select; software owns that
            if (wr && hit_seq) begin
                seq_en_reg <= wd[spcr_pkg::BIT_SEQ_ENABLE];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (defaults) begin
            second_frac_reg <= spcr_pkg::RST_FRAC_MODE;
            second_mult_reg <= spcr_pkg::RST_INT_MULT;
            second_hi_reg   <= spcr_pkg::RST_SECOND_HI;
            second_mid_reg  <= spcr_pkg::RST_SECOND_MID;
            second_lo_reg   <= spcr_pkg::RST_SECOND_LO;
        end else begin
            if (wr && hit_s2i) begin
                second_frac_reg <= wd[spcr_pkg::BIT_FRAC_MODE];
                second_mult_reg <= wd[spcr_pkg::MULT_MSB:0];
            end
            if (wr && hit_s2h) begin
                second_hi_reg <= wd;
            end
            if (wr && hit_s2m) begin
                second_mid_reg <= wd;
            end
            if (wr && hit_s2l) begin
                second_lo_reg <= wd;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (defaults) begin
            third_frac_reg <= spcr_pkg::RST_FRAC_MODE;
            third_mult_reg <= spcr_pkg::RST_INT_MULT;
            third_hi_reg   <= spcr_pkg::RST_THIRD_HI;
            third_mid_reg  <= spcr_pkg::RST_THIRD_MID;
            third_lo_reg   <= spcr_pkg::RST_THIRD_LO;
        end else begin
            if (wr && hit_s3i) begin
                third_frac_reg <= wd[spcr_pkg::BIT_FRAC_MODE];
                third_mult_reg <= wd[spcr_pkg::MULT_MSB:0];
            end
            if (wr && hit_s3h) begin
                third_hi_reg <= wd;
            end
            if (wr && hit_s3m) begin
                third_mid_reg <= wd;
            end
            if (wr && hit_s3l) begin
                third_lo_reg <= wd;
            end
        end
    end

    // reserved bits are not stored; they always read one

    // reference clock routing; a plain mux, glitches on switch
    wire ref_clk = ref_sel_reg ? master_clk_in : internal_osc_clk;
    assign second_synth_ref_clk = second_eff ? ref_clk : 1'b0;
    assign third_synth_ref_clk  = !third_eff ? 1'b0 :
        (from_fll_reg ? freq_locked_loop_clk : ref_clk);

    assign avs_waitrequest        = access && (state_reg == spcr_pkg::SPCR_IDLE);
    assign avs_readdata           = rdata_reg;
    assign internal_osc_enable    = osc_eff;
    assign second_synth_enable    = second_eff;
    assign third_synth_enable     = third_eff;
    assign second_synth_frac_mode = second_frac_reg;
    assign second_synth_int_mult  = second_mult_reg;
    assign second_synth_frac_mult = {second_hi_reg, second_mid_reg,
                                     second_lo_reg};
    assign third_synth_frac_mode  = third_frac_reg;
    assign third_synth_int_mult   = third_mult_reg;
    assign third_synth_frac_mult  = {third_hi_reg, third_mid_reg,
                                     third_lo_reg};
    assign synth_ref_select       = ref_sel_reg;
    assign third_synth_from_fll   = from_fll_reg;
    assign synth_sequencer_enable = seq_en_reg;
endmodule
`default_nettype wire

// ---- core/spcr_sync.sv ----
// three-stage synchroniser with agreement filter for a pin input
`timescale 1ns/100ps
`default_nettype none
module spcr_sync #(
    parameter logic RESET_VAL = 1'b0
) (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic pin_in,
    output logic      level_out
);
    logic meta_reg;
    logic mid_reg;
    logic last_reg;
    logic level_reg;
    wire  agree = (mid_reg == last_reg);

    always_ff @(posedge clk) begin
        if (rst) begin
            meta_reg  <= RESET_VAL;
            mid_reg   <= RESET_VAL;
            last_reg  <= RESET_VAL;
            level_reg <= RESET_VAL;
        end else begin
            meta_reg <= pin_in;
            mid_reg  <= meta_reg;
            last_reg <= mid_reg;
            if (agree) begin
                level_reg <= last_reg;
            end
        end
    end

    assign level_out = level_reg;
endmodule
`default_nettype wire

// ---- tb/spcr_regs_sva.sv ----
// assertions on the synthesizer configuration register ports
`timescale 1ns/100ps
`default_nettype none
module spcr_regs_sva (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic [9:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic        clock_lockout_override,
    input wire logic        boot_strap_pin,
    input wire logic        internal_osc_clk,
    input wire logic        master_clk_in,
    input wire logic        freq_locked_loop_clk,
    input wire logic        internal_osc_enable,
    input wire logic        second_synth_enable,
    input wire logic        third_synth_enable,
    input wire logic        second_synth_ref_clk,
    input wire logic        third_synth_ref_clk,
    input wire logic [4:0]  second_synth_int_mult,
    input wire logic [23:0] second_synth_frac_mult,
    input wire logic [4:0]  third_synth_int_mult,
    input wire logic [23:0] third_synth_frac_mult,
    input wire logic        synth_ref_select,
    input wire logic        third_synth_from_fll,
    input wire logic        synth_sequencer_enable
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    property p_wait_first;
        (avs_read || avs_write) && !$past(avs_read || avs_write)
            |-> avs_waitrequest;
    endproperty
    a_wait_first: assert property (p_wait_first)
        else $error("new request without wait state");

    property p_one_wait;
        avs_waitrequest |=> !avs_waitrequest;
    endproperty
    a_one_wait: assert property (p_one_wait)
        else $error("wait state longer than one cycle");

    // lag of the pin synchroniser is covered by eight cycles
    property p_osc_locked;
        (!clock_lockout_override && !boot_strap_pin) [*8]
            |-> !internal_osc_enable;
    endproperty
    a_osc_locked: assert property (p_osc_locked)
        else $error("oscillator enabled while locked");

    property p_second_locked;
        !clock_lockout_override [*8] |-> !second_synth_enable;
    endproperty
    a_second_locked: assert property (p_second_locked)
        else $error("second synth enabled while locked");

    property p_third_locked;
        !clock_lockout_override [*8] |-> !third_synth_enable;
    endproperty
    a_third_locked: assert property (p_third_locked)
        else $error("third synth enabled while locked");

    property p_release;
        $rose(clock_lockout_override)
            |-> ##[1:10] (second_synth_enable && third_synth_enable);
    endproperty
    a_release: assert property (p_release)
        else $error("enables not on after override");

    property p_second_mux;
        second_synth_ref_clk == (second_synth_enable &&
            (synth_ref_select ? master_clk_in : internal_osc_clk));
    endproperty
    a_second_mux: assert property (p_second_mux)
        else $error("second synth reference wrong");

    property p_third_mux;
        third_synth_ref_clk == (third_synth_enable && (third_synth_from_fll ?
            freq_locked_loop_clk :
            (synth_ref_select ? master_clk_in : internal_osc_clk)));
    endproperty
    a_third_mux: assert property (p_third_mux)
        else $error("third synth reference wrong");

    property p_defaults;
        $fell(rst) |-> second_synth_int_mult == 5'h07 &&
            third_synth_int_mult == 5'h07 &&
            second_synth_frac_mult == 24'h1c_71c7 &&
            third_synth_frac_mult[23:8] == 16'h4822 &&
            !synth_ref_select && !third_synth_from_fll &&
            synth_sequencer_enable;
    endproperty
    a_defaults: assert property (p_defaults)
        else $error("field not at default after reset");

    property p_soft_reset;
        avs_write && !avs_waitrequest && avs_address == 10'h1fc
            |=> second_synth_int_mult == 5'h07 && !synth_ref_select &&
            synth_sequencer_enable && third_synth_int_mult == 5'h07;
    endproperty
    a_soft_reset: assert property (p_soft_reset)
        else $error("soft reset left a field changed");

    property p_upper_zero;
        avs_readdata[31:8] == 24'h00_0000;
    endproperty
    a_upper_zero: assert property (p_upper_zero)
        else $error("read data upper bits set");
endmodule
bind spcr_regs spcr_regs_sva chk (.*);
`default_nettype wire

// ---- tb/spcr_regs_tb.sv ----
// self-checking bench for the synthesizer configuration registers
`timescale 1ns/100ps
`default_nettype none
module spcr_regs_tb;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [9:0]  avs_address = 10'h000;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [3:0]  avs_byteenable = 4'hf;
    logic        clock_lockout_override = 1'b0;
    logic        boot_strap_pin = 1'b0;
    logic [2:0]  ck_cnt = 3'h0;
    logic [31:0] avs_readdata, q;
    logic        avs_waitrequest, internal_osc_enable, second_synth_enable;
    logic        third_synth_enable, second_synth_ref_clk, third_synth_ref_clk;
    logic        second_synth_frac_mode, third_synth_frac_mode;
    logic        synth_ref_select, third_synth_from_fll, synth_sequencer_enable;
    logic [4:0]  second_synth_int_mult, third_synth_int_mult;
    logic [23:0] second_synth_frac_mult, third_synth_frac_mult;
    int          bad_count = 0;
    int          n_checks = 0;
    localparam logic [7:0] DIDX [11] = '{8'h81, 8'h83, 8'h88, 8'h89, 8'h8a,
        8'h8b, 8'h8c, 8'h8d, 8'h8e, 8'h8f, 8'h96};
    localparam logic [7:0] DVAL [11] = '{8'h01, 8'h10, 8'h47, 8'h1c, 8'h71,
        8'hc7, 8'h47, 8'h48, 8'h22, 8'h00, 8'h03};

    spcr_regs uut (
        .clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable, .avs_readdata, .avs_waitrequest,
        .clock_lockout_override, .boot_strap_pin,
        .internal_osc_clk(ck_cnt[0]), .master_clk_in(ck_cnt[1]),
        .freq_locked_loop_clk(ck_cnt[2]), .internal_osc_enable,
        .second_synth_enable, .third_synth_enable, .second_synth_ref_clk,
        .third_synth_ref_clk, .second_synth_frac_mode, .second_synth_int_mult,
        .second_synth_frac_mult, .third_synth_frac_mode, .third_synth_int_mult,
        .third_synth_frac_mult, .synth_ref_select, .third_synth_from_fll,
        .synth_sequencer_enable);

    always #20 clk = ~clk;
    // three slow reference clocks, all launched from the bench clock edge
    always @(posedge clk) ck_cnt <= ck_cnt + 3'h1;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic bus(input logic w, input logic [9:0] a,
                       input logic [7:0] d, output logic [31:0] r);
        int n;
        n = 0;
        avs_address <= a;
        avs_writedata <= {24'h00_0000, d};
        avs_write <= w;
        avs_read <= !w;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        r = avs_readdata;
        if (n >= 50) begin
            bad_count++;
            end_of_test();
        end
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        // idle edge so the next request is not raised in this time step
        @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        bus(1'b1, {idx, 2'b00}, d, q);
    endtask

    task automatic rd(input logic [7:0] idx, input logic [7:0] e);
        bus(1'b0, {idx, 2'b00}, 8'h00, q);
        check(q, {24'h00_0000, e});
    endtask

    // pins pass a synchroniser, so give them time to land
    task automatic pins(input logic ovd, input logic strap);
        clock_lockout_override <= ovd;
        boot_strap_pin <= strap;
        repeat (12) @(posedge clk);
    endtask

    task automatic muxchk(input int s2, input int s3);
        repeat (4) begin
            @(negedge clk);
            check(32'(second_synth_ref_clk), 32'(ck_cnt[s2]));
            check(32'(third_synth_ref_clk), 32'(ck_cnt[s3]));
        end
        @(posedge clk);
    endtask

    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        for (int i = 0; i < 11; i++) rd(DIDX[i], DVAL[i]);
        wr(8'h81, 8'hb1);
        rd(8'h81, 8'h01);
        check(32'({internal_osc_enable, second_synth_enable,
                   third_synth_enable}), 32'h0);
        $display("test locked defaults done");
        pins(1'b0, 1'b1);
        rd(8'h81, 8'h81);
        wr(8'h81, 8'h01);
        rd(8'h81, 8'h01);
        check(32'(internal_osc_enable), 32'h0);
        pins(1'b0, 1'b0);
        rd(8'h81, 8'h01);
        $display("test strap done");
        pins(1'b1, 1'b0);
        rd(8'h81, 8'hb1);
        check(32'({internal_osc_enable, second_synth_enable,
                   third_synth_enable}), 32'h7);
        wr(8'h81, 8'h01);
        rd(8'h81, 8'h01);
        check(32'(second_synth_enable), 32'h0);
        wr(8'h81, 8'hb1);
        $display("test override done");
        // sequencer is cleared before the master clock is chosen
        wr(8'h96, 8'h01);
        wr(8'h83, 8'h12);
        rd(8'h83, 8'h12);
        check(32'({synth_ref_select, synth_sequencer_enable}), 32'h2);
        muxchk(1, 1);
        wr(8'h83, 8'h13);
        rd(8'h83, 8'h13);
        muxchk(1, 2);
        wr(8'h83, 8'h10);
        muxchk(0, 0);
        $display("test reference mux done");
        for (int s = 0; s < 2; s++) begin
            wr(8'h88 + 8'(4 * s), 8'h1f);
            wr(8'h89 + 8'(4 * s), 8'ha5);
            wr(8'h8a + 8'(4 * s), 8'h5a);
            wr(8'h8b + 8'(4 * s), 8'h3c);
            rd(8'h88 + 8'(4 * s), 8'h1f);
        end
        check(32'({second_synth_frac_mode, second_synth_int_mult,
                   second_synth_frac_mult}), 32'h1fa5_5a3c);
        check(32'({third_synth_frac_mode, third_synth_int_mult,
                   third_synth_frac_mult}), 32'h1fa5_5a3c);
        $display("test fields done");
        rd(8'h84, 8'h00);
        bus(1'b1, 10'h221, 8'h00, q);
        avs_byteenable <= 4'h0;
        wr(8'h88, 8'h00);
        avs_byteenable <= 4'hf;
        rd(8'h88, 8'h1f);
        $display("test refused access done");
        wr(8'h81, 8'h01);
        wr(8'h83, 8'h13);
        wr(8'h7f, 8'h00);
        rd(8'h81, 8'hb1);
        for (int i = 1; i < 11; i++) rd(DIDX[i], DVAL[i]);
        $display("test soft reset done");
        pins(1'b0, 1'b0);
        rd(8'h81, 8'h01);
        wr(8'h81, 8'hb1);
        rd(8'h81, 8'h01);
        check(32'({second_synth_enable, third_synth_enable}), 32'h0);
        $display("test relock done");
        end_of_test();
    end
endmodule
`default_nettype wire
